//--- stpg_defs.vh
// Constants for the self-test packet generator and checker.
// Assumes a 40 MHz system clock and an AXI4-Lite register bus.
// What this block does
// - Count received test bytes in sixteen bits
// - Byte count visible is frozen by lock writes
// - Byte counter saturates when wrap mode zero
// - Packet overflow flag bit 10 until clear
// - Byte overflow flag bit 9 until clear
// - Count error bytes in eight bits, frozen
// - Error counter saturates when wrap mode zero
// - Bit 0 write captures counters, no clear
// - Bit 1 write captures then clears counters and flags
// - Packet holds exactly programmed length bytes
// - Frame starts seven 0x55 bytes, then 0xD5
// - Gap is four bytes per field unit
`ifndef STPG_DEFS_VH
`define STPG_DEFS_VH
// Printed offsets are register indices; byte address is four times
`define STPG_IDX_BYTE_CNT 8'h71
`define STPG_IDX_ERR_CTL 8'h72
`define STPG_IDX_PKT_LEN 8'h7B
`define STPG_IDX_GAP 8'h7C
`define STPG_IDX_MODE 8'h80
`define STPG_IDX_IRQ_STAT 8'h81
`define STPG_IDX_IRQ_MASK 8'h82
`define STPG_RST_PKT_LEN 16'h05DC
`define STPG_RST_GAP 8'h7D
`define STPG_BIT_LOCK 0
`define STPG_BIT_CLEAR 1
`define STPG_BIT_BYTE_OVF 9
`define STPG_BIT_PKT_OVF 10
`define STPG_BIT_GEN_EN 0
`define STPG_BIT_WRAP 1
`define STPG_PRE_NIBBLES 4'hD
`define STPG_PRE_BYTES 3'h7
`define STPG_PRE_BYTE 8'h55
`define STPG_SFD_BYTE 8'hD5
`define STPG_GAP_SHIFT 2
`define STPG_LFSR_SEED 8'hFF
`define STPG_RESP_OKAY 2'h0
`define STPG_RESP_SLVERR 2'h2
`define STPG_IRQ_BITS 3
`endif

//--- stpg_checker.v
// Checker for the self-test stream: counts bytes, errors and packets.
// Assumes rx data is synchronous to clk_sys and the lock/clear pulses are one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "stpg_defs.vh"
module stpg_checker (
    input wire clk_sys,
    input wire reset,
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_sop,
    input wire wrap_mode,
    input wire lock_pulse,
    input wire clear_pulse,
    output reg [15:0] byte_snap_r,
    output reg [7:0] err_snap_r,
    output reg byte_ovf_r,
    output reg pkt_ovf_r,
    output reg err_event_r
);
    reg [15:0] byte_cnt_r;
    reg [7:0] err_cnt_r;
    reg [15:0] pkt_cnt_r;
    reg [7:0] exp_lfsr_r;
    reg in_pkt_r;
    wire [7:0] exp_byte;
    wire byte_err;
    wire byte_take;
    wire byte_wrap_ev;
    wire pkt_ovf_ev;

    // Next LFSR state, x^8+x^6+x^5+x^4+1
    function [7:0] lfsr_step;
        input [7:0] s;
        begin
            lfsr_step = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
        end
    endfunction

    // Expected byte; the first of a packet reseeds the checker
    assign exp_byte = rx_sop ? `STPG_LFSR_SEED : exp_lfsr_r;
    assign byte_err = rx_valid && (rx_sop || in_pkt_r) && (rx_data != exp_byte);

    // Byte accepted, and the two overflow events
    assign byte_take = rx_valid && (rx_sop || in_pkt_r);
    assign byte_wrap_ev = byte_take && (byte_cnt_r == 16'hFFFF) && wrap_mode;
    assign pkt_ovf_ev = rx_valid && rx_sop && (pkt_cnt_r == 16'hFFFF);

    // Live counters with saturate or wrap behaviour
    always @(posedge clk_sys) begin
        if (reset || clear_pulse) begin
            byte_cnt_r <= 16'h0000;
            err_cnt_r <= 8'h00;
            pkt_cnt_r <= 16'h0000;
            // An overflow in the clear cycle still sets its flag
            byte_ovf_r <= !reset && byte_wrap_ev;
            pkt_ovf_r <= !reset && pkt_ovf_ev;
            exp_lfsr_r <= `STPG_LFSR_SEED;
            in_pkt_r <= 1'b0;
            err_event_r <= 1'b0;
        end else begin
            err_event_r <= byte_err;
            if (rx_valid && (rx_sop || in_pkt_r)) begin
                in_pkt_r <= 1'b1;
                exp_lfsr_r <= lfsr_step(exp_byte);
                if (byte_cnt_r != 16'hFFFF)
                    byte_cnt_r <= byte_cnt_r + 16'h0001;
                else if (wrap_mode) begin
                    byte_cnt_r <= 16'h0000;
                    byte_ovf_r <= 1'b1;
                end
            end else if (!rx_valid)
                in_pkt_r <= 1'b0; // Packet ends when the stream goes idle
            if (byte_err) begin
                if (err_cnt_r != 8'hFF)
                    err_cnt_r <= err_cnt_r + 8'h01;
                else if (wrap_mode)
                    err_cnt_r <= 8'h00;
            end
            if (rx_valid && rx_sop) begin
                if (pkt_cnt_r != 16'hFFFF)
                    pkt_cnt_r <= pkt_cnt_r + 16'h0001;
                else begin
                    pkt_ovf_r <= 1'b1;
                    if (wrap_mode)
                        pkt_cnt_r <= 16'h0000;
                end
            end
        end
    end

    // Software-visible copies, updated only by a lock or clear write
    always @(posedge clk_sys) begin
        if (reset) begin
            byte_snap_r <= 16'h0000;
            err_snap_r <= 8'h00;
        end else if (lock_pulse || clear_pulse) begin
            byte_snap_r <= byte_cnt_r;
            err_snap_r <= err_cnt_r;
        end
    end
endmodule // stpg_checker
`default_nettype wire

//--- stpg_top.v
// Self-test packet generator and checker with AXI4-Lite registers.
// Assumes one clock clk_sys, synchronous active-high reset, single-beat bus.
`timescale 1ns/100ps
`default_nettype none
`include "stpg_defs.vh"
module stpg_top (
    input wire clk_sys,
    input wire reset,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [7:0] tx_data_r,
    output reg tx_valid_r,
    output reg tx_sop_r,
    output reg tx_eop_r,
    input wire [7:0] rx_data,
    input wire rx_valid,
    input wire rx_sop,
    output reg irq_r
);
    localparam ST_IDLE = 2'h0;
    localparam ST_PRE = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_GAP = 2'h3;

    reg [15:0] pkt_len_r;
    reg [7:0] gap_len_r;
    reg gen_en_r;
    reg wrap_mode_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;
    reg lock_pulse_r;
    reg clear_pulse_r;
    reg [11:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;
    reg [1:0] gen_state_r;
    reg [17:0] gen_cnt_r;
    reg [7:0] gen_lfsr_r;
    reg pkt_done_r;
    reg [31:0] rd_word;
    reg rd_ok;
    wire [15:0] byte_snap;
    wire [7:0] err_snap;
    wire byte_ovf;
    wire pkt_ovf;
    wire err_event;
    wire [2:0] irq_events;
    wire wr_fire;
    wire [7:0] wr_idx;
    wire [7:0] rd_idx;

    // Register index from a byte address; other bits must be zero
    function [7:0] reg_index;
        input [11:0] addr;
        begin
            reg_index = addr[9:2];
        end
    endfunction

    // Next LFSR state, same polynomial as the checker
    function [7:0] lfsr_step;
        input [7:0] s;
        begin
            lfsr_step = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
        end
    endfunction

    stpg_checker u_checker (
        .clk_sys(clk_sys),
        .reset(reset),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_sop(rx_sop),
        .wrap_mode(wrap_mode_r),
        .lock_pulse(lock_pulse_r),
        .clear_pulse(clear_pulse_r),
        .byte_snap_r(byte_snap),
        .err_snap_r(err_snap),
        .byte_ovf_r(byte_ovf),
        .pkt_ovf_r(pkt_ovf),
        .err_event_r(err_event)
    );

    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wr_idx = reg_index(aw_addr_r);
    assign rd_idx = reg_index(s_axi_araddr);
    // Events: packet sent, error byte seen, counter overflow
    assign irq_events = {byte_ovf | pkt_ovf, err_event, pkt_done_r};

    // Write channel capture; address and data taken in either order
    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `STPG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                if (aw_addr_r[11:10] != 2'h0 || aw_addr_r[1:0] != 2'h0)
                    s_axi_bresp <= `STPG_RESP_SLVERR;
                else if (wr_idx == `STPG_IDX_BYTE_CNT || wr_idx == `STPG_IDX_ERR_CTL ||
                         wr_idx == `STPG_IDX_PKT_LEN || wr_idx == `STPG_IDX_GAP ||
                         wr_idx == `STPG_IDX_MODE || wr_idx == `STPG_IDX_IRQ_STAT ||
                         wr_idx == `STPG_IDX_IRQ_MASK)
                    s_axi_bresp <= `STPG_RESP_OKAY;
                else
                    s_axi_bresp <= `STPG_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register writes, lock/clear pulses and sticky interrupt status
    always @(posedge clk_sys) begin
        if (reset) begin
            pkt_len_r <= `STPG_RST_PKT_LEN;
            gap_len_r <= `STPG_RST_GAP;
            gen_en_r <= 1'b0;
            wrap_mode_r <= 1'b0;
            irq_mask_r <= 3'h0;
            irq_stat_r <= 3'h0;
            lock_pulse_r <= 1'b0;
            clear_pulse_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            lock_pulse_r <= 1'b0;
            clear_pulse_r <= 1'b0;
            irq_r <= |(irq_stat_r & irq_mask_r);
            if (wr_fire && aw_addr_r[11:10] == 2'h0 && aw_addr_r[1:0] == 2'h0) begin
                if (wr_idx == `STPG_IDX_ERR_CTL) begin
                    if (w_strb_r[0]) begin
                        lock_pulse_r <= w_data_r[`STPG_BIT_LOCK];
                        clear_pulse_r <= w_data_r[`STPG_BIT_CLEAR];
                    end
                end else if (wr_idx == `STPG_IDX_PKT_LEN) begin
                    if (w_strb_r[0])
                        pkt_len_r[7:0] <= w_data_r[7:0];
                    if (w_strb_r[1])
                        pkt_len_r[15:8] <= w_data_r[15:8];
                end else if (wr_idx == `STPG_IDX_GAP) begin
                    if (w_strb_r[0])
                        gap_len_r <= w_data_r[7:0];
                end else if (wr_idx == `STPG_IDX_MODE) begin
                    if (w_strb_r[0]) begin
                        gen_en_r <= w_data_r[`STPG_BIT_GEN_EN];
                        wrap_mode_r <= w_data_r[`STPG_BIT_WRAP];
                    end
                end else if (wr_idx == `STPG_IDX_IRQ_MASK) begin
                    if (w_strb_r[0])
                        irq_mask_r <= w_data_r[`STPG_IRQ_BITS-1:0];
                end
            end
            // New events win over a write-one clear in the same cycle
            if (wr_fire && wr_idx == `STPG_IDX_IRQ_STAT && w_strb_r[0] &&
                aw_addr_r[11:10] == 2'h0 && aw_addr_r[1:0] == 2'h0)
                irq_stat_r <= (irq_stat_r & ~w_data_r[`STPG_IRQ_BITS-1:0]) | irq_events;
            else
                irq_stat_r <= irq_stat_r | irq_events;
        end
    end

    // Read data mux; reserved bits read zero
    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
        if (rd_idx == `STPG_IDX_BYTE_CNT)
            rd_word = {16'h0000, byte_snap};
        else if (rd_idx == `STPG_IDX_ERR_CTL)
            rd_word = {21'h000000, pkt_ovf, byte_ovf, 1'b0, err_snap};
        else if (rd_idx == `STPG_IDX_PKT_LEN)
            rd_word = {16'h0000, pkt_len_r};
        else if (rd_idx == `STPG_IDX_GAP)
            rd_word = {24'h000000, gap_len_r};
        else if (rd_idx == `STPG_IDX_MODE)
            rd_word = {30'h0000_0000, wrap_mode_r, gen_en_r};
        else if (rd_idx == `STPG_IDX_IRQ_STAT)
            rd_word = {29'h0000_0000, irq_stat_r};
        else if (rd_idx == `STPG_IDX_IRQ_MASK)
            rd_word = {29'h0000_0000, irq_mask_r};
        else
            rd_ok = 1'b0;
    end

    // Read channel: one cycle from address to data
    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `STPG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? `STPG_RESP_OKAY : `STPG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Generator: preamble, delimiter, payload, gap
    always @(posedge clk_sys) begin
        if (reset) begin
            gen_state_r <= ST_IDLE;
            gen_cnt_r <= 18'h00000;
            gen_lfsr_r <= `STPG_LFSR_SEED;
            tx_data_r <= 8'h00;
            tx_valid_r <= 1'b0;
            tx_sop_r <= 1'b0;
            tx_eop_r <= 1'b0;
            pkt_done_r <= 1'b0;
        end else begin
            tx_sop_r <= 1'b0;
            tx_eop_r <= 1'b0;
            pkt_done_r <= 1'b0;
            case (gen_state_r)
                ST_IDLE: begin
                    tx_valid_r <= 1'b0;
                    gen_cnt_r <= 18'h00000;
                    if (gen_en_r && pkt_len_r != 16'h0000)
                        gen_state_r <= ST_PRE;
                end
                ST_PRE: begin
                    // Seven 0x55 bytes sent whole, then the 0xD5 delimiter byte
                    tx_valid_r <= 1'b1;
                    if (gen_cnt_r[2:0] == `STPG_PRE_BYTES) begin
                        tx_data_r <= `STPG_SFD_BYTE;
                        gen_cnt_r <= 18'h00000;
                        gen_lfsr_r <= `STPG_LFSR_SEED;
                        gen_state_r <= ST_DATA;
                    end else begin
                        tx_data_r <= `STPG_PRE_BYTE;
                        gen_cnt_r <= gen_cnt_r + 18'h00001;
                    end
                end
                ST_DATA: begin
                    tx_valid_r <= 1'b1;
                    tx_data_r <= gen_lfsr_r;
                    tx_sop_r <= (gen_cnt_r == 18'h00000);
                    gen_lfsr_r <= lfsr_step(gen_lfsr_r);
                    if (gen_cnt_r[15:0] == pkt_len_r - 16'h0001) begin
                        tx_eop_r <= 1'b1;
                        pkt_done_r <= 1'b1;
                        gen_cnt_r <= 18'h00000;
                        gen_state_r <= (gap_len_r == 8'h00) ? ST_IDLE : ST_GAP;
                    end else
                        gen_cnt_r <= gen_cnt_r + 18'h00001;
                end
                default: begin
                    tx_valid_r <= 1'b0;
                    if (gen_cnt_r == ({10'h000, gap_len_r} << `STPG_GAP_SHIFT) - 18'h00001) begin
                        gen_cnt_r <= 18'h00000;
                        gen_state_r <= ST_IDLE;
                    end else
                        gen_cnt_r <= gen_cnt_r + 18'h00001;
                end
            endcase
        end
    end
endmodule // stpg_top
`default_nettype wire

//--- stpg_top_checker.sv
// Assertions on the bus and transmit ports of the self-test block.
// Assumes it is bound to stpg_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module stpg_top_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] tx_data_r,
    input wire logic tx_valid_r,
    input wire logic tx_sop_r,
    input wire logic tx_eop_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Answers hold until taken and come on time
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped early");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    // Frame shape on the transmit side
    chk_preamble_run: assert property ($rose(tx_valid_r) |->
        (tx_valid_r && tx_data_r == 8'h55) [*7] ##1 (tx_valid_r && tx_data_r == 8'hD5)
        ##1 tx_sop_r) else $error("bad preamble or delimiter");
    chk_gap_floor: assert property ($fell(tx_valid_r) |-> !tx_valid_r [*4])
        else $error("gap shorter than one unit");
    chk_eop_ends: assert property (tx_eop_r |-> tx_valid_r ##1 !tx_valid_r)
        else $error("frame runs past last byte");
endmodule // stpg_top_checker
bind stpg_top stpg_top_checker stpg_top_checker_inst (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r), .tx_sop_r(tx_sop_r),
    .tx_eop_r(tx_eop_r));
`default_nettype wire

//--- stpg_link_model.sv
// Loopback model of the link: returns the generated stream to the checker.
// Assumes one clock; corrupt inverts every payload byte while high.
`timescale 1ns/100ps
`default_nettype none
module stpg_link_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_sop,
    input wire logic tx_eop,
    input wire logic corrupt,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_sop
);
    logic in_pl_r;
    // One-cycle loopback; idle data toggles so no stale byte lingers
    always @(posedge clk_sys) begin
        if (reset) begin
            in_pl_r <= 1'h0;
            rx_valid <= 1'h0;
            rx_sop <= 1'h0;
            rx_data <= 8'h00;
        end else begin
            in_pl_r <= tx_eop ? 1'h0 : (tx_sop | in_pl_r);
            rx_valid <= tx_valid;
            rx_sop <= tx_sop;
            if (tx_valid) rx_data <= tx_data ^ ((corrupt && (tx_sop || in_pl_r)) ? 8'hFF : 8'h00);
            else rx_data <= ~rx_data;
        end
    end
endmodule // stpg_link_model
`default_nettype wire

//--- stpg_tb.sv
// Self-checking bench for the self-test packet generator and checker.
// Assumes stpg_top with its AXI4-Lite slave and the loopback link model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys = 1'h0, reset = 1'h1, corrupt = 1'h0, in_pl = 1'h0, seen_eop = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic awrdy, wrdy, bv, arrdy, rv, irq, txv, txs, txe, rxv, rxs;
    logic [1:0] bresp, rresp, rr;
    logic [7:0] txd, rxd;
    int errors = 0, total_checks = 0, pkts = 0, nbytes = 0, nerrs = 0, fi = 0, gapc = 0;
    int len = 1500, gap = 125, snap;
    stpg_top stpg_top_inst (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .tx_data_r(txd), .tx_valid_r(txv), .tx_sop_r(txs),
        .tx_eop_r(txe), .rx_data(rxd), .rx_valid(rxv), .rx_sop(rxs), .irq_r(irq));
    stpg_link_model stpg_link_model_inst (.clk_sys(clk_sys), .reset(reset), .tx_data(txd),
        .tx_valid(txv), .tx_sop(txs), .tx_eop(txe), .corrupt(corrupt), .rx_data(rxd),
        .rx_valid(rxv), .rx_sop(rxs));
    // 40 MHz clock
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic print_verdict();
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask
    task automatic fail_out();
        chk("handshake", 32'h1, 32'h0);
        print_verdict();
    endtask
    // Expected counter value after n events, saturating or wrapping
    function automatic logic [31:0] sat(input int n, input int mx, input logic wrap);
        if (wrap) return 32'(n % (mx + 1));
        return 32'((n > mx) ? mx : n);
    endfunction
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (awv && awrdy) awv <= 1'h0;
            if (wv && wrdy) wv <= 1'h0;
            if (bv) begin
                chk("write resp", 32'h0, bresp);
                break;
            end
        end
        bready <= 1'h0;
        if (n == 64) fail_out();
    endtask
    task automatic rd_reg(input logic [7:0] idx);
        int n;
        @(posedge clk_sys);
        araddr <= {2'h0, idx, 2'h0};
        arv <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (arv && arrdy) arv <= 1'h0;
            if (rv) break;
        end
        rd = rdata;
        rr = rresp;
        rready <= 1'h0;
        if (n == 64) fail_out();
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        rd_reg(idx);
        chk(nm, exp, rd);
    endtask
    // Runs the generator for n packets, then stops it and lets the link drain
    task automatic run(input int n, input logic wrap);
        int k;
        wr(8'h80, {30'h0, wrap, 1'h1});
        for (k = 0; k < 70000 && pkts < n; k++) @(posedge clk_sys);
        if (pkts < n) fail_out();
        wr(8'h80, {30'h0, wrap, 1'h0});
        for (k = 0; k < 200 && txv; k++) @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
        seen_eop = 1'h0;
        pkts = 0;
        if (txv) fail_out();
    endtask
    // Watches the generated stream and tallies expected byte and error counts
    always @(posedge clk_sys) begin
        if (txv) begin
            if (fi < 7) chk("preamble", 32'h55, txd);
            if (fi == 7) chk("delimiter", 32'hD5, txd);
            if (fi == 0 && seen_eop) chk("gap cycles", 4 * gap + 1, gapc);
            if (txs || in_pl) nbytes++;
            if ((txs || in_pl) && corrupt) nerrs++;
            if (txe) chk("frame bytes", 8 + len, fi + 1);
            if (txe) pkts++;
            in_pl <= txe ? 1'h0 : (txs | in_pl);
            seen_eop <= txe;
            fi <= fi + 1;
            gapc <= 0;
        end else begin
            fi <= 0;
            gapc <= gapc + 1;
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'hC99A));
        repeat (8) @(posedge clk_sys);
        reset <= 1'h0;
        rd_chk("count reset", 8'h71, 32'h0);
        rd_chk("errs reset", 8'h72, 32'h0);
        rd_chk("length reset", 8'h7B, 32'h5DC);
        rd_chk("gap reset", 8'h7C, 32'h7D);
        rd_reg(8'h90);
        chk("unmapped resp", 32'h2, rr);
        wr(8'h7C, 32'hFFFF);
        rd_chk("gap reserved", 8'h7C, 32'hFF);
        wr(8'h72, 32'hFFFC);
        rd_chk("err reserved", 8'h72, 32'h0);
        wr(8'h71, 32'h1234);
        rd_chk("count read only", 8'h71, 32'h0);
        len = 4 + $urandom % 29;
        gap = 2 + $urandom % 3;
        wr(8'h7B, 32'(len));
        wr(8'h7C, 32'(gap));
        wr(8'h82, 32'h1);
        run(3, 1'h0);
        chk("irq raised", 32'h1, irq);
        wr(8'h72, 32'h1);
        rd_chk("count locked", 8'h71, nbytes);
        rd_chk("no errs", 8'h72, 32'h0);
        corrupt <= 1'h1;
        run(2, 1'h0);
        wr(8'h72, 32'h1);
        rd_chk("lock keeps count", 8'h71, nbytes);
        rd_chk("errs counted", 8'h72, nerrs);
        rd_reg(8'h81);
        chk("status pkt", 32'h1, rd[0]);
        wr(8'h81, 32'h7);
        wr(8'h82, 32'h0);
        snap = nbytes;
        run(1, 1'h0);
        chk("irq masked", 32'h0, irq);
        wr(8'h82, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk("irq unmasked", 32'h1, irq);
        rd_chk("count frozen", 8'h71, snap);
        wr(8'h72, 32'h2);
        rd_chk("count at clear", 8'h71, nbytes);
        nbytes = 0;
        nerrs = 0;
        wr(8'h72, 32'h1);
        rd_chk("count cleared", 8'h71, 32'h0);
        len = 200;
        wr(8'h7B, 32'hC8);
        run(2, 1'h0);
        wr(8'h72, 32'h2);
        rd_chk("errs saturate", 8'h72, sat(nerrs, 255, 1'h0));
        nbytes = 0;
        nerrs = 0;
        run(2, 1'h1);
        wr(8'h72, 32'h2);
        rd_chk("errs wrap", 8'h72, sat(nerrs, 255, 1'h1));
        corrupt <= 1'h0;
        nbytes = 0;
        nerrs = 0;
        len = 32769;
        wr(8'h7B, 32'h8001);
        run(2, 1'h0);
        wr(8'h72, 32'h1);
        rd_chk("count saturate", 8'h71, sat(nbytes, 65535, 1'h0));
        rd_chk("no byte ovf", 8'h72, 32'h0);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
